/* File: switch_port_tuning_csr.sv */
`include "port_tuning_consts.svh"
`default_nettype none
// Contract
// (RULE1) Defaults of these fields may be replaced by SMBus, I2C or EEPROM autoload.
// (RULE2) Upstream-only fields come from the upstream copy and apply switch-wide.
// (RULE3) Bit 6 is read-write, resets 0, disables relaxed ordering; only EEPROM reloads it.
// (RULE4) Bit 10 read-only, resets 0; loaded one disables the port.
// (RULE5) Bits 9:8 hold rate-change attempt count, reset 00b.
// (RULE6) Bit 11 is upstream reset select, reset to one.
// (RULE7) Bits 23:16 mirror aux PHY byte, reset 79h; bit 16 suppresses error retrain.
// (RULE8) PHY word bits 6:0 give per-lane mode, read-only, reset 00h.
// (RULE9) PHY word bits 31:15 carry upstream global delta, read-only, reset 0_0001h.
// (RULE10) Writes to read-only fields are ignored; reserved bits read zero.
module switch_port_tuning_csr (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Configuration space access, same clock.
   input wire port_tuning_pkg::cfg_req_t cfg_req_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_ack_o,
   // Default loader, same clock.
   input wire port_tuning_pkg::load_req_t load_req_i,
   input wire port_tuning_pkg::load_src_t load_src_i,
   // Upstream strap and upstream copies of the global fields, from another port's clock.
   input wire logic is_upstream_i,
   input wire logic [31:0] up_tlc_i,
   input wire logic [16:0] up_delta_i,
   // Control outputs.
   output logic ordering_rule_off_o,
   output logic port_disable_o,
   output logic [1:0] rate_change_attempt_count_o,
   output logic reset_select_o,
   output logic [7:0] aux_phy_control_byte_o,
   output logic phy_retrain_off_o,
   output logic [6:0] lane_mode_o,
   output logic [16:0] phy_delta_o
);
   import port_tuning_pkg::*;

   logic [31:0] tlc_local;
   logic [31:0] phyp_local;
   logic up_is_s;
   logic [31:0] up_tlc_s;
   logic [16:0] up_delta_s;
   logic [48:0] up_prev_r;
   logic [48:0] up_held_r;
   logic up_settled;
   logic [31:0] up_tlc_h;
   logic [16:0] up_delta_h;
   logic [31:0] tlc_view;
   logic [31:0] phyp_view;
   logic [31:0] tlc_load_mask;
   logic tlc_sel_hit;
   logic phyp_sel_hit;
   logic tlc_load;
   logic phyp_load;
   logic tlc_sw_wr;
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;
   logic ack_r;
   logic ordering_r;
   logic port_dis_r;
   logic [1:0] cnt_r;
   logic rsel_r;
   logic [7:0] aux_r;
   logic retrain_r;
   logic [6:0] lane_r;
   logic [16:0] delta_r;

   function automatic logic [31:0] merge_up(input logic [31:0] own, input logic [31:0] up,
                                            input logic [31:0] msk);
      merge_up = (own & ~msk) | (up & msk);
   endfunction

   // Register select for configuration reads and writes; the default loader selects by tlc_sel.
   assign tlc_sel_hit = (cfg_req_i.addr == `TLC_OFFSET);
   assign phyp_sel_hit = (cfg_req_i.addr == `PHYP_OFFSET);

   // Bit 6 is loadable by the EEPROM only, so other sources are masked off it.
   assign tlc_load_mask = (load_src_i == SRC_EEPROM) ? 32'hffff_ffff
                        : ~(32'h0000_0001 << `TLC_RO_MASK_BIT); // [RULE3]
   assign tlc_load = load_req_i.load && load_req_i.tlc_sel
                     && (load_src_i != SRC_NONE); // [RULE1]
   assign phyp_load = load_req_i.load && !load_req_i.tlc_sel
                      && (load_src_i != SRC_NONE); // [RULE1]
   assign tlc_sw_wr = cfg_req_i.wr && tlc_sel_hit; // [RULE10]

   tuning_word #(
      .RESET_VAL(`TLC_RESET),
      .VALID_MASK(`TLC_VALID_MASK),
      .SW_MASK(32'h0000_0001 << `TLC_RO_MASK_BIT)
   ) u_tlc (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .load_i(tlc_load),
      .load_mask_i(tlc_load_mask),
      .load_data_i(load_req_i.data),
      .sw_wr_i(tlc_sw_wr),
      .sw_data_i(cfg_req_i.wdata),
      .value_o(tlc_local)
   );

   // The PHY word is never software writable.
   tuning_word #(
      .RESET_VAL(`PHYP_RESET),
      .VALID_MASK(`PHYP_VALID_MASK),
      .SW_MASK(32'h0000_0000)
   ) u_phyp (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .load_i(phyp_load),
      .load_mask_i(32'hffff_ffff),
      .load_data_i(load_req_i.data),
      .sw_wr_i(1'b0),
      .sw_data_i(32'h0000_0000),
      .value_o(phyp_local)
   );

   sideband_sync #(
      .W(50)
   ) u_up_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .async_i({is_upstream_i, up_tlc_i, up_delta_i}),
      .sync_o({up_is_s, up_tlc_s, up_delta_s})
   );

   // The copies come from another clock with no strobe, so a word is taken only once two
   // samples agree; a word caught halfway through a change never reaches the outputs.
   assign up_settled = ({up_tlc_s, up_delta_s} == up_prev_r);
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         up_prev_r <= 49'h0;
         up_held_r <= 49'h0;
      end else begin
         up_prev_r <= {up_tlc_s, up_delta_s};
         if (up_settled) begin
            up_held_r <= up_prev_r;
         end
      end
   end
   assign up_tlc_h = up_held_r[48:17];
   assign up_delta_h = up_held_r[16:0];

   // Downstream ports show the upstream copy of every switch-wide field.
   assign tlc_view = up_is_s ? tlc_local
                   : merge_up(tlc_local, up_tlc_h & `TLC_VALID_MASK,
                              `TLC_UP_ONLY_MASK); // [RULE2]
   assign phyp_view = up_is_s ? phyp_local
                    : merge_up(phyp_local, {up_delta_h, 15'h0000},
                               32'hffff_8000); // [RULE2] [RULE9]

   // Reserved bits already read zero through the valid masks.
   assign rdata_nxt = !cfg_req_i.rd ? rdata_r
                    : tlc_sel_hit ? tlc_view
                    : phyp_sel_hit ? (phyp_view & `PHYP_VALID_MASK)
                    : 32'h0000_0000; // [RULE10]

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0000_0000;
         ack_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ack_r <= cfg_req_i.rd || cfg_req_i.wr;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ordering_r <= 1'b0;
         port_dis_r <= 1'b0;
         cnt_r <= 2'b00;
         rsel_r <= 1'b1;
         aux_r <= 8'h79;
         retrain_r <= 1'b1;
         lane_r <= 7'h00;
         delta_r <= 17'h00001;
      end else begin
         ordering_r <= tlc_view[`TLC_RO_MASK_BIT]; // [RULE3]
         port_dis_r <= tlc_view[`TLC_PORT_DIS_BIT]; // [RULE4]
         cnt_r <= tlc_view[`TLC_CNT_LSB +: 2]; // [RULE5]
         rsel_r <= tlc_view[`TLC_RESET_SEL_BIT]; // [RULE6]
         aux_r <= tlc_view[`TLC_AUX_LSB +: 8]; // [RULE7]
         retrain_r <= tlc_view[`TLC_AUX_LSB]; // [RULE7]
         lane_r <= phyp_view[6:0]; // [RULE8]
         delta_r <= phyp_view[31:15]; // [RULE9]
      end
   end

   assign cfg_rdata_o = rdata_r;
   assign cfg_ack_o = ack_r;
   assign ordering_rule_off_o = ordering_r;
   assign port_disable_o = port_dis_r;
   assign rate_change_attempt_count_o = cnt_r;
   assign reset_select_o = rsel_r;
   assign aux_phy_control_byte_o = aux_r;
   assign phy_retrain_off_o = retrain_r;
   assign lane_mode_o = lane_r;
   assign phy_delta_o = delta_r;

   property p_eeprom_only_bit6;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (tlc_load && load_src_i != SRC_EEPROM && !tlc_sw_wr)
      |=> ($stable(tlc_local[6]));
   endproperty
   a_eeprom_only_bit6: assert property (p_eeprom_only_bit6) // [RULE3]
      else $error("bit 6 changed by a non-EEPROM load");

   property p_sw_write_bit6;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (tlc_sw_wr && !tlc_load) |=> (tlc_local[6] == $past(cfg_req_i.wdata[6]));
   endproperty
   a_sw_write_bit6: assert property (p_sw_write_bit6) // [RULE3]
      else $error("software write to bit 6 not taken");

   property p_ro_ignored;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (tlc_sw_wr && !tlc_load) |=> ((tlc_local & 32'hffff_ffbf)
                                   == $past(tlc_local & 32'hffff_ffbf));
   endproperty
   a_ro_ignored: assert property (p_ro_ignored) // [RULE10]
      else $error("software write changed a read-only bit");

   property p_reserved_zero;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (cfg_req_i.rd && tlc_sel_hit) |=> ((cfg_rdata_o & 32'h4000_e000) == 32'h0000_0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [RULE10]
      else $error("reserved bits read nonzero");

   property p_port_disable;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      1'b1 |=> (port_disable_o == $past(tlc_view[10]));
   endproperty
   a_port_disable: assert property (p_port_disable) // [RULE4]
      else $error("port disable does not follow bit 10");

   property p_retrain;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      1'b1 |-> (phy_retrain_off_o == aux_phy_control_byte_o[0]);
   endproperty
   a_retrain: assert property (p_retrain) // [RULE7]
      else $error("retrain suppression disagrees with aux byte bit 0");

   property p_up_global;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !up_is_s |=> (phy_delta_o == $past(up_delta_h));
   endproperty
   a_up_global: assert property (p_up_global) // [RULE2] [RULE9]
      else $error("downstream delta differs from upstream copy");

   property p_load_takes;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      phyp_load |=> (phyp_local == ($past(load_req_i.data) & `PHYP_VALID_MASK));
   endproperty
   a_load_takes: assert property (p_load_takes) // [RULE1] [RULE8]
      else $error("loaded PHY default not stored");

   property p_count;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      1'b1 |=> (rate_change_attempt_count_o == $past(tlc_view[9:8]));
   endproperty
   a_count: assert property (p_count) // [RULE5]
      else $error("attempt count does not follow bits 9:8");

   property p_rsel;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      1'b1 |=> (reset_select_o == $past(tlc_view[11]));
   endproperty
   a_rsel: assert property (p_rsel) // [RULE6]
      else $error("reset select does not follow bit 11");

   property p_phy_reserved_zero;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (cfg_req_i.rd && phyp_sel_hit) |=> ((cfg_rdata_o & 32'h0000_7f80) == 32'h0000_0000);
   endproperty
   a_phy_reserved_zero: assert property (p_phy_reserved_zero) // [RULE10]
      else $error("PHY word reserved bits read nonzero");

   property p_phy_no_sw_write;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (cfg_req_i.wr && phyp_sel_hit && !phyp_load) |=> $stable(phyp_local);
   endproperty
   a_phy_no_sw_write: assert property (p_phy_no_sw_write) // [RULE8] [RULE10]
      else $error("software write changed the PHY word");

   property p_unmapped_zero;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (cfg_req_i.rd && !tlc_sel_hit && !phyp_sel_hit) |=> (cfg_rdata_o == 32'h0000_0000);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) // [RULE10]
      else $error("unmapped read returned nonzero data");

   property p_up_ordering;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !up_is_s |=> (ordering_rule_off_o == $past(up_tlc_h[6]));
   endproperty
   a_up_ordering: assert property (p_up_ordering) // [RULE2] [RULE3]
      else $error("downstream ordering control differs from upstream copy");

   property p_lane;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      1'b1 |=> (lane_mode_o == $past(phyp_local[6:0]));
   endproperty
   a_lane: assert property (p_lane) // [RULE8]
      else $error("lane mode does not follow the local PHY word");
endmodule // switch_port_tuning_csr
`default_nettype wire

/* File: port_tuning_consts.svh */
`ifndef PORT_TUNING_CONSTS_SVH
`define PORT_TUNING_CONSTS_SVH
`define TLC_OFFSET 8'h8c
`define PHYP_OFFSET 8'h90
`define TLC_RESET 32'h0079_1894
`define TLC_RO_MASK_BIT 6
`define TLC_PORT_DIS_BIT 10
`define TLC_RESET_SEL_BIT 11
`define TLC_CNT_LSB 8
`define TLC_AUX_LSB 16
`define TLC_VALID_MASK 32'hbfff_1fff
`define TLC_UP_ONLY_MASK 32'h3c00_10ef
`define PHYP_RESET 32'h0000_8000
`define PHYP_VALID_MASK 32'hffff_807f
`define PHYP_LANE_MASK 32'h0000_007f
`endif

/* File: port_tuning_pkg.sv */
`default_nettype none
package port_tuning_pkg;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } cfg_req_t;
   typedef struct packed {
      logic load;
      logic tlc_sel;
      logic [31:0] data;
   } load_req_t;
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_SMBUS,
      SRC_I2C,
      SRC_EEPROM
   } load_src_t;
endpackage
`default_nettype wire

/* File: tuning_word.sv */
`include "port_tuning_consts.svh"
`default_nettype none
// One loadable configuration word: reset constant, sideband default load, masked software write.
module tuning_word #(
   parameter logic [31:0] RESET_VAL = 32'h0000_0000,
   parameter logic [31:0] VALID_MASK = 32'hffff_ffff,
   parameter logic [31:0] SW_MASK = 32'h0000_0000
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Default load and software write.
   input wire logic load_i,
   input wire logic [31:0] load_mask_i,
   input wire logic [31:0] load_data_i,
   input wire logic sw_wr_i,
   input wire logic [31:0] sw_data_i,
   // Stored value.
   output logic [31:0] value_o
);
   logic [31:0] value_r;
   logic [31:0] value_nxt;
   logic [31:0] lmask;
   assign lmask = load_mask_i & VALID_MASK;
   assign value_nxt = load_i ? ((value_r & ~lmask) | (load_data_i & lmask))
                    : sw_wr_i ? ((value_r & ~SW_MASK) | (sw_data_i & SW_MASK))
                    : value_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         value_r <= RESET_VAL;
      end else begin
         value_r <= value_nxt;
      end
   end
   assign value_o = value_r & VALID_MASK;
endmodule // tuning_word
`default_nettype wire

/* File: sideband_sync.sv */
`default_nettype none
// Two-flop synchroniser for the upstream strap and the upstream copies of the global words.
module sideband_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end
   assign sync_o = sync_r;
endmodule // sideband_sync
`default_nettype wire

/* File: tb_switch_port_tuning_csr.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import port_tuning_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   cfg_req_t cfg_req_i = '0;
   load_req_t load_req_i = '0;
   load_src_t load_src_i = SRC_NONE;
   logic is_upstream_i = 1'b1;
   logic [31:0] up_tlc_i = 32'hffff_ffff;
   logic [16:0] up_delta_i = 17'h1_ffff;
   logic [31:0] cfg_rdata_o;
   logic cfg_ack_o;
   logic ordering_rule_off_o;
   logic port_disable_o;
   logic [1:0] rate_change_attempt_count_o;
   logic reset_select_o;
   logic [7:0] aux_phy_control_byte_o;
   logic phy_retrain_off_o;
   logic [6:0] lane_mode_o;
   logic [16:0] phy_delta_o;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] rd_val;

   always #2 core_clk_i = ~core_clk_i;

   switch_port_tuning_csr i_dut (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .cfg_req_i(cfg_req_i),
      .cfg_rdata_o(cfg_rdata_o),
      .cfg_ack_o(cfg_ack_o),
      .load_req_i(load_req_i),
      .load_src_i(load_src_i),
      .is_upstream_i(is_upstream_i),
      .up_tlc_i(up_tlc_i),
      .up_delta_i(up_delta_i),
      .ordering_rule_off_o(ordering_rule_off_o),
      .port_disable_o(port_disable_o),
      .rate_change_attempt_count_o(rate_change_attempt_count_o),
      .reset_select_o(reset_select_o),
      .aux_phy_control_byte_o(aux_phy_control_byte_o),
      .phy_retrain_off_o(phy_retrain_off_o),
      .lane_mode_o(lane_mode_o),
      .phy_delta_o(phy_delta_o)
   );

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Retrain suppression is expected to follow bit zero of the aux byte.
   function automatic logic [37:0] exp_outs(input logic ord, input logic dis,
         input logic [1:0] cnt, input logic rsel, input logic [7:0] aux,
         input logic [6:0] lane, input logic [16:0] dlt);
      return {ord, dis, cnt, rsel, aux, aux[0], lane, dlt};
   endfunction

   task automatic chk_outs(input logic [37:0] exp);
      chk(64'({ordering_rule_off_o, port_disable_o, rate_change_attempt_count_o,
         reset_select_o, aux_phy_control_byte_o, phy_retrain_off_o, lane_mode_o,
         phy_delta_o}), 64'(exp), "outputs");
   endtask

   task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
         input logic [31:0] wd);
      @(posedge core_clk_i);
      #1 cfg_req_i = '{rd: rd, wr: wr, addr: addr, wdata: wd};
      @(posedge core_clk_i);
      #1 cfg_req_i = '0;
      chk(64'(cfg_ack_o), 64'h1, "ack");
      rd_val = cfg_rdata_o;
      @(posedge core_clk_i);
      #1 chk(64'(cfg_ack_o), 64'h0, "ack drop");
   endtask

   task automatic read_chk(input logic [7:0] addr, input logic [31:0] exp);
      access(1'b1, 1'b0, addr, 32'h0000_0000);
      chk(64'(rd_val), 64'(exp), "read data");
   endtask

   task automatic load(input load_src_t src, input logic sel, input logic [31:0] d);
      @(posedge core_clk_i);
      #1 load_req_i = '{load: 1'b1, tlc_sel: sel, data: d};
      load_src_i = src;
      @(posedge core_clk_i);
      #1 load_req_i = '0;
      load_src_i = SRC_NONE;
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask

   task automatic do_reset(input logic up);
      #1 rst_b_i = 1'b0;
      is_upstream_i = up;
      repeat (10) @(posedge core_clk_i);
      #1 rst_b_i = 1'b1;
      repeat (5) @(posedge core_clk_i);
      #1;
   endtask

   // The upstream copies carry all ones here, so any leak shows up.
   task automatic t_reset();
      read_chk(8'h8c, 32'h0079_1894);
      read_chk(8'h90, 32'h0000_8000);
      read_chk(8'h94, 32'h0000_0000);
      chk_outs(exp_outs(1'b0, 1'b0, 2'h0, 1'b1, 8'h79, 7'h00, 17'h0_0001));
   endtask

   task automatic t_sw_write();
      access(1'b0, 1'b1, 8'h8c, 32'hffff_ffff);
      read_chk(8'h8c, 32'h0079_18d4);
      chk(64'(ordering_rule_off_o), 64'h1, "ordering off");
      access(1'b0, 1'b1, 8'h90, 32'hffff_ffff);
      read_chk(8'h90, 32'h0000_8000);
      access(1'b0, 1'b1, 8'h8c, 32'h0000_0000);
      read_chk(8'h8c, 32'h0079_1894);
      access(1'b1, 1'b1, 8'h8c, 32'h0000_0040);
      chk(64'(rd_val), 64'h0079_1894, "read beside write");
      read_chk(8'h8c, 32'h0079_18d4);
      access(1'b0, 1'b1, 8'h8c, 32'h0000_0000);
   endtask

   task automatic t_load();
      load_src_t srcs [3] = '{SRC_SMBUS, SRC_I2C, SRC_EEPROM};
      logic b6;
      foreach (srcs[i]) begin
         b6 = (srcs[i] == SRC_EEPROM);
         load(srcs[i], 1'b1, 32'hffff_ffff);
         read_chk(8'h8c, 32'hbfff_1fbf | {25'h0, b6, 6'h00});
         chk_outs(exp_outs(b6, 1'b1, 2'h3, 1'b1, 8'hff, 7'h00, 17'h0_0001));
         load(srcs[i], 1'b1, 32'h0000_0000);
         read_chk(8'h8c, 32'h0000_0000);
         chk_outs(exp_outs(1'b0, 1'b0, 2'h0, 1'b0, 8'h00, 7'h00, 17'h0_0001));
      end
      load(SRC_NONE, 1'b1, 32'hffff_ffff);
      read_chk(8'h8c, 32'h0000_0000);
      load(SRC_I2C, 1'b0, 32'hffff_ffff);
      read_chk(8'h90, 32'hffff_807f);
      chk_outs(exp_outs(1'b0, 1'b0, 2'h0, 1'b0, 8'h00, 7'h7f, 17'h1_ffff));
   endtask

   // A downstream port takes the switch-wide fields from the synchronised upstream copy.
   task automatic t_downstream();
      up_tlc_i = 32'hffff_ffff;
      up_delta_i = 17'h1_2345;
      do_reset(1'b0);
      chk_outs(exp_outs(1'b1, 1'b0, 2'h0, 1'b1, 8'h79, 7'h00, 17'h1_2345));
      load(SRC_EEPROM, 1'b1, 32'h0000_0000);
      repeat (3) @(posedge core_clk_i);
      #1;
      chk_outs(exp_outs(1'b1, 1'b0, 2'h0, 1'b0, 8'h00, 7'h00, 17'h1_2345));
      read_chk(8'h8c, 32'h3c00_10ef);
      read_chk(8'h90, 32'h91a2_8000);
   endtask

   task automatic wrap_up();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge core_clk_i);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      do_reset(1'b1);
      t_reset();
      t_sw_write();
      t_load();
      t_downstream();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
